//--- rtl/serial_prog_pkg.sv
// constants for the serial programming and debug port
package serial_prog_pkg;
    localparam int CMD_W = 6;
    localparam int WORD_W = 14;
    localparam int ID_W = 7;
    localparam int EE_W = 8;
    localparam int ADDR_W = 14;
    localparam int SYNC_W = 2;
    // commands, six bits
    localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
    localparam logic [5:0] CMD_LOAD_PROG = 6'h02;
    localparam logic [5:0] CMD_LOAD_DATA = 6'h03;
    localparam logic [5:0] CMD_READ_PROG = 6'h04;
    localparam logic [5:0] CMD_READ_DATA = 6'h05;
    localparam logic [5:0] CMD_INC_ADDR = 6'h06;
    localparam logic [5:0] CMD_BULK_ERASE = 6'h09;
    // address map
    localparam logic [13:0] PC_RESET = 14'h0000;
    localparam logic [13:0] ID_BASE = 14'h2000;
    localparam logic [13:0] ID_LAST = 14'h2003;
    localparam logic [13:0] CFG_ADDR = 14'h2007;
    // configuration word fields and erased values
    localparam int CFG_CP_BIT = 6;
    localparam int CFG_CPD_BIT = 7;
    localparam int CFG_DBG_BIT = 12;
    localparam logic [13:0] CFG_ERASED = 14'h3FFF;
    localparam logic [13:0] WORD_ERASED = 14'h3FFF;
    localparam logic [7:0] EE_ERASED = 8'hFF;
    localparam logic [6:0] ID_ERASED = 7'h7F;
    typedef enum logic [1:0] {PH_CMD, PH_LOAD, PH_READ} link_phase_t;
endpackage : serial_prog_pkg

//--- rtl/serial_program_debug_port.sv
// serial programming and in-circuit debug port, device side
//
// Functional notes
// - In program mode the data and clock pins are Schmitt-trigger programming inputs.
// - On entry to program mode the address counter starts at zero.
// - Each transfer is a 6-bit command followed, for loads and reads, by 14 data bits.
// - Program memory reads back only while code protection is off.
// - Turning code protection off erases all data memory and program memory.
// - The four user ID words are reachable only in program mode, never by fetch.
// - Only the low seven bits of each user ID word are kept.
// - Debug is enabled only when configuration bit 12 is zero.
// - With debug enabled the debugger owns the clock and data pins.
// - In debug the data pin has a TTL input and the clock pin a Schmitt input.
`timescale 1ns/100ps
`default_nettype none
module serial_program_debug_port
    import serial_prog_pkg::*;
#(
    parameter int PROG_DEPTH = 256,
    parameter int EE_DEPTH   = 256
) (
    input  wire logic              SYS_CLK,
    input  wire logic              RST_B,
    input  wire logic              SERIAL_PROG_CLOCK_PIN,
    output logic                   SERIAL_PROG_CLOCK_PIN_OUT,
    output logic                   SERIAL_PROG_CLOCK_PIN_OE,
    input  wire logic              SERIAL_PROG_DATA_PIN_IN,
    output logic                   SERIAL_PROG_DATA_PIN_OUT,
    output logic                   SERIAL_PROG_DATA_PIN_OE,
    input  wire logic              MASTER_CLEAR_HIGH,
    input  wire logic              APP_CLOCK_OUT,
    input  wire logic              APP_CLOCK_OE,
    input  wire logic              APP_DATA_OUT,
    input  wire logic              APP_DATA_OE,
    input  wire logic              DEBUG_CLOCK_LINE_OUT,
    input  wire logic              DEBUG_CLOCK_LINE_OE,
    input  wire logic              DEBUG_DATA_LINE_OUT,
    input  wire logic              DEBUG_DATA_LINE_OE,
    input  wire logic [ADDR_W-1:0] FETCH_ADDR,
    output logic      [WORD_W-1:0] FETCH_DATA,
    output logic                   PROG_MODE,
    output logic                   DEBUG_ENABLE,
    output logic                   DATA_PIN_TTL_SEL,
    output logic                   ERASE_BUSY
);
    localparam int PA  = $clog2(PROG_DEPTH);
    localparam int EEA = $clog2(EE_DEPTH);
    localparam int EA  = (PA > EEA) ? PA : EEA;

    function automatic logic is_load(input logic [CMD_W-1:0] c);
        return (c == CMD_LOAD_PROG) || (c == CMD_LOAD_DATA) || (c == CMD_LOAD_CFG);
    endfunction : is_load

    function automatic logic is_read(input logic [CMD_W-1:0] c);
        return (c == CMD_READ_PROG) || (c == CMD_READ_DATA);
    endfunction : is_read

    // --------------------------------------------------------------
    // pin synchronisers and mode entry
    // --------------------------------------------------------------
    logic [SYNC_W-1:0] vpp_s_r;
    logic [SYNC_W-1:0] clk_s_r;
    logic [SYNC_W-1:0] dat_s_r;
    logic [SYNC_W-1:0] tog_s_r;
    logic              vpp_d_r;
    logic              tog_d_r;
    logic              tog_r;
    logic              mode_r;
    logic              entry;
    logic              link_rst_b;

    // two flops per asynchronous input
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            vpp_s_r <= '0;
            clk_s_r <= '0;
            dat_s_r <= '0;
            tog_s_r <= '0;
            vpp_d_r <= 1'b0;
            tog_d_r <= 1'b0;
        end else begin
            vpp_s_r <= {vpp_s_r[0], MASTER_CLEAR_HIGH};
            clk_s_r <= {clk_s_r[0], SERIAL_PROG_CLOCK_PIN};
            dat_s_r <= {dat_s_r[0], SERIAL_PROG_DATA_PIN_IN};
            tog_s_r <= {tog_s_r[0], tog_r};
            vpp_d_r <= vpp_s_r[1];
            tog_d_r <= tog_s_r[1];
        end
    end

    // high level rises while clock and data sit low
    assign entry = vpp_s_r[1] & ~vpp_d_r & ~clk_s_r[1] & ~dat_s_r[1];

    // program mode lasts while the high level stays
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_r <= 1'b0;
        end else if (entry) begin
            mode_r <= 1'b1;
        end else if (!vpp_s_r[1]) begin
            mode_r <= 1'b0;
        end
    end

    assign link_rst_b = mode_r;
    assign PROG_MODE  = mode_r;

    // --------------------------------------------------------------
    // link side, clocked by the host clock pin
    // --------------------------------------------------------------
    link_phase_t       phase_r;
    logic [4:0]        cnt_r;
    logic [CMD_W-1:0]  cmd_sh_r;
    logic [CMD_W-1:0]  cmd_r;
    logic [WORD_W-1:0] dat_sh_r;
    logic [WORD_W-1:0] data_r;
    logic              oe_r;
    logic [CMD_W-1:0]  cmd_nxt;
    logic [WORD_W-1:0] rd_prog_r;
    logic [WORD_W-1:0] rd_ee_r;

    assign cmd_nxt = {SERIAL_PROG_DATA_PIN_IN, cmd_sh_r[CMD_W-1:1]};

    // command then data shifter, lsb first on rising edges
    always_ff @(posedge SERIAL_PROG_CLOCK_PIN or negedge link_rst_b) begin
        if (!link_rst_b) begin
            phase_r  <= PH_CMD;
            cnt_r    <= '0;
            cmd_sh_r <= '0;
            cmd_r    <= '0;
            dat_sh_r <= '0;
            data_r   <= '0;
            tog_r    <= 1'b0;
            oe_r     <= 1'b0;
        end else begin
            case (phase_r)
                PH_CMD: begin
                    cmd_sh_r <= cmd_nxt;
                    if (cnt_r == 5'(CMD_W - 1)) begin
                        cnt_r <= '0;
                        cmd_r <= cmd_nxt;
                        if (is_read(cmd_nxt)) begin
                            phase_r  <= PH_READ;
                            oe_r     <= 1'b1;
                            dat_sh_r <= (cmd_nxt == CMD_READ_DATA) ? rd_ee_r : rd_prog_r;
                        end else if (is_load(cmd_nxt)) begin
                            phase_r <= PH_LOAD;
                        end else begin
                            tog_r <= ~tog_r;
                        end
                    end else begin
                        cnt_r <= cnt_r + 5'd1;
                    end
                end
                PH_LOAD: begin
                    dat_sh_r <= {SERIAL_PROG_DATA_PIN_IN, dat_sh_r[WORD_W-1:1]};
                    if (cnt_r == 5'(WORD_W - 1)) begin
                        cnt_r   <= '0;
                        phase_r <= PH_CMD;
                        data_r  <= {SERIAL_PROG_DATA_PIN_IN, dat_sh_r[WORD_W-1:1]};
                        tog_r   <= ~tog_r;
                    end else begin
                        cnt_r <= cnt_r + 5'd1;
                    end
                end
                PH_READ: begin
                    dat_sh_r <= {1'b0, dat_sh_r[WORD_W-1:1]};
                    if (cnt_r == 5'(WORD_W - 1)) begin
                        cnt_r   <= '0;
                        phase_r <= PH_CMD;
                        oe_r    <= 1'b0;
                        tog_r   <= ~tog_r;
                    end else begin
                        cnt_r <= cnt_r + 5'd1;
                    end
                end
                default: phase_r <= PH_CMD;
            endcase
        end
    end

    a_cmd_bit_count: assert property (@(posedge SERIAL_PROG_CLOCK_PIN) disable iff (!link_rst_b)
        (phase_r == PH_CMD && cnt_r == 5'd5) |=> (cnt_r == 5'd0))
        else $error("command not closed after six bits");
    a_read_drive: assert property (@(posedge SERIAL_PROG_CLOCK_PIN) disable iff (!link_rst_b)
        (phase_r == PH_READ && cnt_r == 5'd0) |-> oe_r [*8])
        else $error("read data not driven");

    // --------------------------------------------------------------
    // command execution and storage
    // --------------------------------------------------------------
    logic [WORD_W-1:0] prog_mem [PROG_DEPTH];
    logic [EE_W-1:0]   ee_mem [EE_DEPTH];
    logic [ID_W-1:0]   id_r [4];
    logic [WORD_W-1:0] cfg_r;
    logic [ADDR_W-1:0] pc_r;
    logic              req;
    logic              er_busy_r;
    logic [EA-1:0]     er_idx_r;
    logic              in_prog;
    logic              in_id;
    logic              unprotect;
    logic              er_start;

    assign req       = (tog_s_r[1] ^ tog_d_r) & mode_r & ~er_busy_r;
    assign in_prog   = pc_r < ADDR_W'(PROG_DEPTH);
    assign in_id     = (pc_r >= ID_BASE) && (pc_r <= ID_LAST);
    assign unprotect = (~cfg_r[CFG_CP_BIT] & data_r[CFG_CP_BIT])
                     | (~cfg_r[CFG_CPD_BIT] & data_r[CFG_CPD_BIT]);
    assign er_start  = req & ((cmd_r == CMD_BULK_ERASE)
                     | (cmd_r == CMD_LOAD_PROG && pc_r == CFG_ADDR && unprotect));

    // address counter
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pc_r <= PC_RESET;
        end else if (entry) begin
            pc_r <= PC_RESET;
        end else if (req && cmd_r == CMD_INC_ADDR) begin
            pc_r <= pc_r + 14'h0001;
        end else if (req && cmd_r == CMD_LOAD_CFG) begin
            pc_r <= ID_BASE;
        end
    end

    // erase sweep over both arrays
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            er_busy_r <= 1'b0;
            er_idx_r  <= '0;
        end else if (er_start) begin
            er_busy_r <= 1'b1;
            er_idx_r  <= '0;
        end else if (er_busy_r) begin
            er_idx_r  <= er_idx_r + EA'(1);
            er_busy_r <= ~(&er_idx_r);
        end
    end

    // configuration word and user ids
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_r <= CFG_ERASED;
            id_r  <= '{default: ID_ERASED};
        end else if (req && cmd_r == CMD_BULK_ERASE) begin
            cfg_r <= CFG_ERASED;
            id_r  <= '{default: ID_ERASED};
        end else if (req && cmd_r == CMD_LOAD_PROG) begin
            if (pc_r == CFG_ADDR) begin
                cfg_r <= data_r;
            end
            if (unprotect && pc_r == CFG_ADDR) begin
                id_r <= '{default: ID_ERASED};
            end else if (in_id) begin
                id_r[pc_r[1:0]] <= data_r[ID_W-1:0];
            end
        end
    end

    // program and data memories, no reset
    always_ff @(posedge SYS_CLK) begin
        if (er_busy_r) begin
            if (int'(er_idx_r) < PROG_DEPTH) prog_mem[er_idx_r[PA-1:0]] <= WORD_ERASED;
            if (int'(er_idx_r) < EE_DEPTH) ee_mem[er_idx_r[EEA-1:0]] <= EE_ERASED;
        end else if (req && cmd_r == CMD_LOAD_PROG && in_prog) begin
            prog_mem[pc_r[PA-1:0]] <= data_r;
        end else if (req && cmd_r == CMD_LOAD_DATA && pc_r < ADDR_W'(EE_DEPTH)) begin
            ee_mem[pc_r[EEA-1:0]] <= data_r[EE_W-1:0];
        end
    end

    // read words offered to the link, held steady between commands
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_prog_r <= '0;
            rd_ee_r   <= '0;
        end else begin
            if (in_prog) begin
                rd_prog_r <= cfg_r[CFG_CP_BIT] ? prog_mem[pc_r[PA-1:0]] : '0;
            end else if (in_id) begin
                rd_prog_r <= {7'h00, id_r[pc_r[1:0]]};
            end else if (pc_r == CFG_ADDR) begin
                rd_prog_r <= cfg_r;
            end else begin
                rd_prog_r <= '0;
            end
            if (pc_r < ADDR_W'(EE_DEPTH) && cfg_r[CFG_CPD_BIT]) begin
                rd_ee_r <= {6'h00, ee_mem[pc_r[EEA-1:0]]};
            end else begin
                rd_ee_r <= '0;
            end
        end
    end

    // instruction fetch sees program memory only
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            FETCH_DATA <= '0;
        end else if (FETCH_ADDR < ADDR_W'(PROG_DEPTH)) begin
            FETCH_DATA <= prog_mem[FETCH_ADDR[PA-1:0]];
        end else begin
            FETCH_DATA <= '0;
        end
    end

    assign ERASE_BUSY = er_busy_r;

    a_entry_pc_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        entry |=> (pc_r == 14'h0000))
        else $error("address not zero after entry");
    a_cp_read_blank: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (in_prog && !cfg_r[CFG_CP_BIT]) |=> (rd_prog_r == 14'h0000))
        else $error("protected word read out");
    a_unprotect_erase: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (req && cmd_r == CMD_LOAD_PROG && pc_r == CFG_ADDR && unprotect)
        |=> er_busy_r [*8])
        else $error("no erase on unprotect");
    a_id_seven_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        in_id |=> (rd_prog_r[13:7] == 7'h00))
        else $error("id upper bits not zero");
    a_fetch_hides_id: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (FETCH_ADDR >= ID_BASE) |=> (FETCH_DATA == 14'h0000))
        else $error("fetch reached id space");

    // --------------------------------------------------------------
    // debug enable and pin ownership
    // --------------------------------------------------------------
    logic dbg_r;

    // debug is enabled by a zero configuration bit outside program mode
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dbg_r <= 1'b0;
        end else begin
            dbg_r <= ~cfg_r[CFG_DBG_BIT] & ~mode_r;
        end
    end

    // pin drivers: debugger, programming link, or application port
    always_comb begin
        SERIAL_PROG_CLOCK_PIN_OUT = APP_CLOCK_OUT;
        SERIAL_PROG_CLOCK_PIN_OE  = APP_CLOCK_OE & ~mode_r;
        SERIAL_PROG_DATA_PIN_OUT  = APP_DATA_OUT;
        SERIAL_PROG_DATA_PIN_OE   = APP_DATA_OE;
        if (dbg_r) begin
            SERIAL_PROG_CLOCK_PIN_OUT = DEBUG_CLOCK_LINE_OUT;
            SERIAL_PROG_CLOCK_PIN_OE  = DEBUG_CLOCK_LINE_OE;
            SERIAL_PROG_DATA_PIN_OUT  = DEBUG_DATA_LINE_OUT;
            SERIAL_PROG_DATA_PIN_OE   = DEBUG_DATA_LINE_OE;
        end else if (mode_r) begin
            SERIAL_PROG_DATA_PIN_OUT = dat_sh_r[0];
            SERIAL_PROG_DATA_PIN_OE  = oe_r & (phase_r == PH_READ);
        end
    end

    assign DEBUG_ENABLE     = dbg_r;
    assign DATA_PIN_TTL_SEL = dbg_r;

    a_debug_cfg: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (cfg_r[CFG_DBG_BIT] || mode_r) |=> !DEBUG_ENABLE)
        else $error("debug on without config bit");
    a_debug_pins: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        DEBUG_ENABLE |-> (SERIAL_PROG_DATA_PIN_OE == DEBUG_DATA_LINE_OE
        && SERIAL_PROG_CLOCK_PIN_OE == DEBUG_CLOCK_LINE_OE))
        else $error("debugger lost the pins");
    a_input_buffer: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        PROG_MODE |-> ##1 (!DATA_PIN_TTL_SEL))
        else $error("ttl input in program mode");

endmodule : serial_program_debug_port
`default_nettype wire

//--- tb/prog_host_model.sv
// host-side model of the serial programmer driving the clock and data pins
`timescale 1ns/100ps
`default_nettype none
module prog_host_model
    import serial_prog_pkg::*;
(
    output logic              CLK_PIN,
    output logic              DATA_PIN_OUT,
    input  wire logic         DATA_PIN_IN,
    output logic [WORD_W-1:0] RD_WORD,
    output logic              RD_STB
);
    // clock and data rest low between frames so that entry is possible
    initial begin
        CLK_PIN = 1'b0;
        DATA_PIN_OUT = 1'b0;
        RD_WORD = '0;
        RD_STB = 1'b0;
    end

    // one link clock period of 6 ns, rising edge in the middle
    task automatic pulse();
        #3;
        CLK_PIN = 1'b1;
        #3;
        CLK_PIN = 1'b0;
    endtask : pulse

    // hold the clock line at a level outside frames
    task automatic park(input logic lvl);
        CLK_PIN = lvl;
    endtask : park

    // command then optional data word, both lsb first, one bit per rising edge
    task automatic frame(input logic [CMD_W-1:0] cmd, input logic [WORD_W-1:0] w);
        logic rd;
        logic ld;
        rd = (cmd == CMD_READ_PROG) || (cmd == CMD_READ_DATA);
        ld = (cmd == CMD_LOAD_CFG) || (cmd == CMD_LOAD_PROG) || (cmd == CMD_LOAD_DATA);
        #1.3;
        for (int i = 0; i < CMD_W; i++) begin
            DATA_PIN_OUT = cmd[i];
            pulse();
        end
        if (rd) begin
            DATA_PIN_OUT = ~DATA_PIN_OUT; // released line shows the inverse level
            for (int i = 0; i < WORD_W; i++) begin
                #3;
                RD_WORD[i] = DATA_PIN_IN;
                CLK_PIN = 1'b1;
                #3;
                CLK_PIN = 1'b0;
            end
            RD_STB = 1'b1;
            #1;
            RD_STB = 1'b0;
        end else if (ld) begin
            for (int i = 0; i < WORD_W; i++) begin
                DATA_PIN_OUT = w[i];
                pulse();
            end
        end
        #3;
        DATA_PIN_OUT = 1'b0;
    endtask : frame
endmodule : prog_host_model
`default_nettype wire

//--- tb/serial_program_debug_port_tb.sv
// self-checking bench for the serial programming and debug port
`timescale 1ns/100ps
`default_nettype none
module serial_program_debug_port_tb;
    import serial_prog_pkg::*;
    logic              sys_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              mch = 1'b0;
    logic [3:0]        app_r = 4'h0;
    logic [3:0]        dbg_r = 4'h0;
    logic [ADDR_W-1:0] fetch_addr = '0;
    logic [WORD_W-1:0] w0, w1, w;
    logic [WORD_W-1:0] exp_q[$];
    wire  [WORD_W-1:0] fetch_data, rd_word;
    wire               clk_out, clk_oe, dat_out, dat_oe, prog_mode, dbg_en, ttl_sel, busy;
    wire               host_clk, host_dat, rd_stb;
    int                failures = 0;
    int                checks = 0;

    always #20 sys_clk = ~sys_clk;

    // pin levels: the device wins while it drives, else the host
    wire clk_pin = clk_oe ? clk_out : host_clk;
    wire dat_pin = dat_oe ? dat_out : host_dat;

    serial_program_debug_port #(.PROG_DEPTH(16), .EE_DEPTH(16)) dut (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .SERIAL_PROG_CLOCK_PIN(clk_pin),
        .SERIAL_PROG_CLOCK_PIN_OUT(clk_out), .SERIAL_PROG_CLOCK_PIN_OE(clk_oe),
        .SERIAL_PROG_DATA_PIN_IN(dat_pin), .SERIAL_PROG_DATA_PIN_OUT(dat_out),
        .SERIAL_PROG_DATA_PIN_OE(dat_oe), .MASTER_CLEAR_HIGH(mch),
        .APP_CLOCK_OUT(app_r[3]), .APP_CLOCK_OE(app_r[2]), .APP_DATA_OUT(app_r[1]),
        .APP_DATA_OE(app_r[0]), .DEBUG_CLOCK_LINE_OUT(dbg_r[3]),
        .DEBUG_CLOCK_LINE_OE(dbg_r[2]), .DEBUG_DATA_LINE_OUT(dbg_r[1]),
        .DEBUG_DATA_LINE_OE(dbg_r[0]), .FETCH_ADDR(fetch_addr), .FETCH_DATA(fetch_data),
        .PROG_MODE(prog_mode), .DEBUG_ENABLE(dbg_en), .DATA_PIN_TTL_SEL(ttl_sel),
        .ERASE_BUSY(busy));

    prog_host_model host (.CLK_PIN(host_clk), .DATA_PIN_OUT(host_dat), .DATA_PIN_IN(dat_pin),
        .RD_WORD(rd_word), .RD_STB(rd_stb));

    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] expv);
        checks++;
        if (seen !== expv) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cycles

    // raise or drop the clear pin, then allow the sync and settle time
    task automatic clear_pin(input logic lvl);
        @(posedge sys_clk) mch <= lvl;
        cycles(8);
    endtask : clear_pin

    task automatic op(input logic [CMD_W-1:0] cmd, input logic [WORD_W-1:0] d);
        host.frame(cmd, d);
        cycles(6);
    endtask : op

    task automatic rd(input logic [CMD_W-1:0] cmd, input logic [WORD_W-1:0] expv);
        exp_q.push_back(expv);
        op(cmd, 14'h0000);
    endtask : rd

    // move the address counter onto the configuration word
    task automatic to_cfg();
        op(CMD_LOAD_CFG, 14'h0000);
        repeat (7) op(CMD_INC_ADDR, 14'h0000);
    endtask : to_cfg

    // random drive on both pin sources, check which one reaches the pins
    task automatic pins(input logic dbg);
        logic [3:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 4'($urandom);
            @(posedge sys_clk) begin
                app_r <= v;
                dbg_r <= ~v;
            end
            cycles(1);
            check({10'h000, clk_out, clk_oe, dat_out, dat_oe}, {10'h000, dbg ? ~v : v});
        end
        @(posedge sys_clk) begin
            app_r <= 4'h0;
            dbg_r <= 4'h0;
        end
        cycles(2);
    endtask : pins

    // compare each word read back by the host with the oldest note
    always @(posedge rd_stb) begin
        if (exp_q.size() == 0) begin
            failures++;
            $display("mismatch at %0t: seen %h expected none", $time, rd_word);
        end else
            check(rd_word, exp_q.pop_front());
    end

    initial begin
        #(6000 * 40);
        failures++;
        summarize();
    end

    initial begin
        void'($urandom(66694));
        cycles(12);
        rst_b <= 1'b1;
        cycles(3);
        // ----------------------------------------------
        // entry, program and read back, application pins
        // ----------------------------------------------
        pins(1'b0);
        host.park(1'b1);
        clear_pin(1'b1);
        check({13'h0000, prog_mode}, 14'h0000);
        clear_pin(1'b0);
        host.park(1'b0);
        clear_pin(1'b1);
        check({13'h0000, prog_mode}, 14'h0001);
        @(posedge sys_clk) app_r <= 4'h4;
        cycles(1);
        check({13'h0000, clk_oe}, 14'h0000);
        @(posedge sys_clk) app_r <= 4'h0;
        cycles(1);
        w0 = WORD_W'($urandom);
        w1 = WORD_W'($urandom);
        op(CMD_LOAD_PROG, w0);
        rd(CMD_READ_PROG, w0);
        op(CMD_INC_ADDR, 14'h0000);
        op(CMD_LOAD_PROG, w1);
        op(6'h3F, 14'h0000);
        rd(CMD_READ_PROG, w1);
        op(CMD_LOAD_DATA, w0);
        rd(CMD_READ_DATA, {6'h00, w0[7:0]});
        $display("test program and read done");
        // user ids keep seven bits, then protect the code
        op(CMD_LOAD_CFG, 14'h0000);
        for (int i = 0; i < 4; i++) begin
            w = WORD_W'($urandom);
            op(CMD_LOAD_PROG, w);
            rd(CMD_READ_PROG, {7'h00, w[6:0]});
            op(CMD_INC_ADDR, 14'h0000);
        end
        repeat (3) op(CMD_INC_ADDR, 14'h0000);
        op(CMD_LOAD_PROG, 14'h3F3F);
        clear_pin(1'b0);
        fetch_addr <= PC_RESET;
        cycles(3);
        check(fetch_data, w0);
        fetch_addr <= ID_BASE;
        cycles(3);
        check(fetch_data, 14'h0000);
        $display("test user ids done");
        // protected memories read zero, unprotecting erases them
        clear_pin(1'b1);
        rd(CMD_READ_PROG, 14'h0000);
        rd(CMD_READ_DATA, 14'h0000);
        to_cfg();
        op(CMD_LOAD_PROG, CFG_ERASED);
        check({13'h0000, busy}, 14'h0001);
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            cycles(1);
        check({13'h0000, busy}, 14'h0000);
        clear_pin(1'b0);
        clear_pin(1'b1);
        rd(CMD_READ_PROG, WORD_ERASED);
        rd(CMD_READ_DATA, {6'h00, EE_ERASED});
        op(CMD_LOAD_CFG, 14'h0000);
        rd(CMD_READ_PROG, {7'h00, ID_ERASED});
        $display("test code protection done");
        // debug bit low hands the pins to the debugger
        to_cfg();
        op(CMD_LOAD_PROG, 14'h2FFF);
        clear_pin(1'b0);
        check({12'h000, dbg_en, ttl_sel}, 14'h0003);
        pins(1'b1);
        clear_pin(1'b1);
        check({12'h000, prog_mode, dbg_en}, 14'h0002);
        $display("test debug enable done");
        cycles(10);
        check(WORD_W'(exp_q.size()), 14'h0000);
        summarize();
    end
endmodule : serial_program_debug_port_tb
`default_nettype wire
